// ---- rtl/scfg_pkg.sv ----
// Shared constants and state types of the serial configuration sequencer.
// Assumes both ends and the bench import it; no clock or reset inside.
package scfg_pkg;
  localparam logic [2:0]  MODE_SLAVE_SERIAL = 3'h7;
  localparam int          CLOCK_NS          = 25;
  localparam int          PROG_MIN_NS       = 500;
  localparam int          PROG_MIN_CYC      =
    (PROG_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int          CLEAR_CYC         = 64;
  localparam int          CLR_W             = 7;
  localparam int          PROG_W            = 5;
  localparam logic [31:0] MAX_CHAIN_BITS    = 32'hFFFFFFE0;
  localparam int          ADDR_W            = 24;
  localparam int          BYTE_W            = 8;
  localparam int          FIFO_DEPTH        = 8;
  localparam int          CONFIG_BYTES      = 16;
  localparam int          STARTUP_CLKS      = 8;
  localparam int          SU_W              = 4;
  localparam int          SYNC_W            = 9;
  localparam int          SB_PROG           = 0;
  localparam int          SB_INIT           = 1;
  localparam int          SB_DONE           = 2;
  localparam int          SB_MODE           = 3;
  localparam int          SB_TOG            = 6;
  localparam int          SB_SU             = 7;
  localparam int          SB_OVF            = 8;

  typedef enum logic [2:0] {
    DEV_HOLD    = 3'h0,
    DEV_CLEAR   = 3'h1,
    DEV_WAIT    = 3'h2,
    DEV_LOAD    = 3'h3,
    DEV_STARTUP = 3'h4,
    DEV_DONE    = 3'h5,
    DEV_ERROR   = 3'h6
  } scfg_dev_state_t;

  typedef enum logic [2:0] {
    HOST_IDLE  = 3'h0,
    HOST_PROG  = 3'h1,
    HOST_WAIT  = 3'h2,
    HOST_SHIFT = 3'h3,
    HOST_OK    = 3'h4,
    HOST_FAIL  = 3'h5
  } scfg_host_state_t;
endpackage

// ---- rtl/scfg_if.sv ----
// Configuration pins between the host and the configured device.
// Assumes external pull-ups on the open-drain init and done pins.
`timescale 1ns/1ps
interface scfg_if;
  logic       config_clock_pin;
  logic       din;
  logic       dout;
  logic       program_request_n;
  logic [2:0] mode;
  logic       init_out_dev;
  logic       init_oe_dev;
  logic       init_out_host;
  logic       init_oe_host;
  logic       done_out_dev;
  logic       done_oe_dev;
  logic       init_in;
  logic       done_in;

  // Pins read high unless some driver pulls them low.
  assign init_in = !((init_oe_dev && !init_out_dev) ||
                     (init_oe_host && !init_out_host));
  assign done_in = !(done_oe_dev && !done_out_dev);

  modport dev (
    input  config_clock_pin,
    input  din,
    input  program_request_n,
    input  mode,
    input  init_in,
    input  done_in,
    output dout,
    output init_out_dev,
    output init_oe_dev,
    output done_out_dev,
    output done_oe_dev
  );

  modport host (
    output config_clock_pin,
    output din,
    output program_request_n,
    output mode,
    output init_out_host,
    output init_oe_host,
    input  init_in,
    input  done_in,
    input  dout
  );
endinterface

// ---- rtl/scfg_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module scfg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready,
  output logic                  out_valid
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW:0]      next_count;
  logic             wr;
  logic             rd;

  assign wr       = in_valid && in_ready;
  assign rd       = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (wr && !rd)
      next_count = count + 1'b1;
    else if (rd && !wr)
      next_count = count - 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (wr)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (wr)
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (rd)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count     <= next_count;
      in_ready  <= next_count != FULL_CNT;
      out_valid <= next_count != '0;
    end
  end
endmodule

// ---- rtl/scfg_host.sv ----
// Host end: pulses program request, waits for init, shifts the bitstream.
// Assumes the user fills the FIFO and raises stream_end after the last byte.
`timescale 1ns/1ps
module scfg_host (
  scfg_if.host                link,
  input  wire logic           clock,
  input  wire logic           rst,
  input  wire logic           start,
  input  wire logic           stream_end,
  input  wire logic           hold_init,
  input  wire logic [7:0]     in_data,
  input  wire logic           in_valid,
  output logic                in_ready,
  output logic                busy,
  output logic                success,
  output logic                failure
);
  import scfg_pkg::*;

  scfg_host_state_t    state;
  logic [PROG_W-1:0]   prog_cnt;
  logic [1:0]          ph;
  logic [BYTE_W-1:0]   shreg;
  logic [3:0]          nbits;
  logic [1:0]          s1;
  logic [1:0]          s2;
  logic [1:0]          s3;
  logic [1:0]          filt;
  logic                seen_low;
  logic [BYTE_W-1:0]   f_data;
  logic                f_valid;
  logic                f_ready;
  logic                start_bit;
  logic                pad;

  scfg_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_data   (in_data),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .out_data  (f_data),
    .out_ready (f_ready),
    .out_valid (f_valid)
  );

  // Pin levels count once the second and third stages agree.
  always_ff @(posedge clock)
  begin
    s1 <= {link.done_in, link.init_in};
    s2 <= s1;
    s3 <= s2;
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_filt
      always_ff @(posedge clock)
      begin
        if (rst)
          filt[g] <= 1'b0;
        else if (s2[g] == s3[g])
          filt[g] <= s3[g];
      end
    end
  endgenerate

  assign pad       = stream_end && !f_valid && nbits == 4'h0;
  assign f_ready   = state == HOST_SHIFT && ph == 2'h0 && nbits == 4'h0;
  assign start_bit = ph == 2'h0 && (state == HOST_PROG ||
                     (state == HOST_SHIFT && (nbits != 4'h0 || pad)));

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state    <= HOST_IDLE;
      prog_cnt <= '0;
      seen_low <= 1'b0;
    end
    else
    begin
      unique case (state)
        HOST_IDLE:
        begin
          prog_cnt <= '0;
          seen_low <= 1'b0;
          if (start)
            state <= HOST_PROG;
        end
        HOST_PROG:
        begin
          prog_cnt <= prog_cnt + 1'b1;
          if (prog_cnt == PROG_W'(PROG_MIN_CYC - 1))
            state <= HOST_WAIT;
        end
        HOST_WAIT:
        begin
          if (!filt[0])
            seen_low <= 1'b1;
          if (filt[0] && seen_low)
            state <= HOST_SHIFT;
        end
        HOST_SHIFT:
        begin
          if (filt[1])
            state <= HOST_OK;
          else if (!filt[0])
            state <= HOST_FAIL;
        end
        HOST_OK, HOST_FAIL:
        begin
          if (start)
            state <= HOST_PROG;
          prog_cnt <= '0;
          seen_low <= 1'b0;
        end
        default:
          state <= HOST_IDLE;
      endcase
    end
  end

  // Bit cells of four clocks: data changes at phase 0, rises at 2.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ph    <= 2'h0;
      shreg <= '0;
      nbits <= 4'h0;
      link.din              <= 1'b1;
      link.config_clock_pin <= 1'b0;
    end
    else
    begin
      if (start_bit || ph != 2'h0)
        ph <= ph + 1'b1;
      link.config_clock_pin <= ph[1];
      if (state != HOST_SHIFT)
        nbits <= 4'h0;
      else if (f_ready && f_valid)
      begin
        shreg <= f_data;
        nbits <= 4'h8;
      end
      else if (start_bit && nbits != 4'h0)
      begin
        link.din <= shreg[BYTE_W-1];
        shreg    <= {shreg[BYTE_W-2:0], 1'b0};
        nbits    <= nbits - 1'b1;
      end
      else if (start_bit && pad)
        link.din <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      link.program_request_n <= 1'b1;
      link.mode              <= MODE_SLAVE_SERIAL;
      link.init_out_host     <= 1'b0;
      link.init_oe_host      <= 1'b0;
      busy                   <= 1'b0;
      success                <= 1'b0;
      failure                <= 1'b0;
    end
    else
    begin
      link.program_request_n <= state != HOST_PROG;
      link.mode              <= MODE_SLAVE_SERIAL;
      link.init_oe_host      <= hold_init;
      busy    <= state == HOST_PROG || state == HOST_WAIT ||
                 state == HOST_SHIFT;
      success <= state == HOST_OK;
      failure <= state == HOST_FAIL;
    end
  end
endmodule

// ---- rtl/scfg_device.sv ----
// Device end: clear, load and start-up sequencer with serial capture.
// Assumes the link clock comes from the host and may stop between frames;
// capture logic is cleared while loading is not enabled.
`timescale 1ns/1ps

module scfg_device (
  scfg_if.dev                       link,
  input  wire logic                 clock,
  input  wire logic                 rst,
  output logic [scfg_pkg::BYTE_W-1:0] cfg_byte,
  output logic                      cfg_byte_valid,
  output logic [scfg_pkg::ADDR_W-1:0] config_addr,
  output logic [2:0]                mode_latched,
  output logic                      global_set_reset,
  output logic                      configured,
  output logic                      config_error
);
  import scfg_pkg::*;

  scfg_dev_state_t     state;
  logic [CLR_W-1:0]    clr_cnt;
  logic                load_en;
  logic [SYNC_W-1:0]   s1;
  logic [SYNC_W-1:0]   s2;
  logic [SYNC_W-1:0]   s3;
  logic [SYNC_W-1:0]   filt;
  logic                tog_seen;
  logic                byte_evt;

  logic [BYTE_W-1:0]   sr;
  logic [2:0]          bit_cnt;
  logic [BYTE_W-1:0]   link_byte;
  logic                link_tog;
  logic [ADDR_W-1:0]   byte_cnt;
  logic                own_done;
  logic [SU_W-1:0]     su_cnt;
  logic                su_done;
  logic [31:0]         total_bits;
  logic                overflow;

  // Every value entering from pins or the link domain, except link_byte, passes three stages.
  always_ff @(posedge clock)
  begin
    s1 <= {overflow, su_done, link_tog, link.mode, link.done_in,
           link.init_in, link.program_request_n};
    s2 <= s1;
    s3 <= s2;
  end

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++)
    begin : g_filt
      always_ff @(posedge clock)
      begin
        if (rst)
          filt[g] <= (g == SB_PROG);
        else if (s2[g] == s3[g])
          filt[g] <= s3[g];
      end
    end
  endgenerate

  assign byte_evt = filt[SB_TOG] != tog_seen;

  always_ff @(posedge clock)
  begin
    if (rst)
      tog_seen <= 1'b0;
    else
      tog_seen <= filt[SB_TOG];
  end

  // Reset acts as power-on and starts with the memory clear.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state        <= DEV_CLEAR;
      clr_cnt      <= '0;
      mode_latched <= 3'h0;
    end
    else if (!filt[SB_PROG])
    begin
      state   <= DEV_HOLD;
      clr_cnt <= '0;
    end
    else
    begin
      unique case (state)
        DEV_HOLD:
          state <= DEV_CLEAR;
        DEV_CLEAR:
        begin
          clr_cnt <= clr_cnt + 1'b1;
          if (clr_cnt == CLR_W'(CLEAR_CYC - 1))
            state <= DEV_WAIT;
        end
        DEV_WAIT:
        begin
          clr_cnt <= '0;
          if (filt[SB_INIT])
          begin
            mode_latched <= filt[SB_MODE+2:SB_MODE];
            if (filt[SB_MODE+2:SB_MODE] == MODE_SLAVE_SERIAL)
              state <= DEV_LOAD;
            else
              state <= DEV_ERROR;
          end
        end
        DEV_LOAD:
        begin
          if (filt[SB_OVF])
            state <= DEV_ERROR;
          else if (byte_evt &&
                   config_addr == ADDR_W'(CONFIG_BYTES - 1))
            state <= DEV_STARTUP;
        end
        DEV_STARTUP:
        begin
          if (filt[SB_OVF])
            state <= DEV_ERROR;
          else if (filt[SB_SU])
            state <= DEV_DONE;
        end
        DEV_DONE, DEV_ERROR:
          state <= state;
        default:
          state <= DEV_ERROR;
      endcase
    end
  end

  // Loaded bytes, numbered by their byte address.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cfg_byte       <= '0;
      cfg_byte_valid <= 1'b0;
      config_addr    <= '0;
    end
    else
    begin
      cfg_byte_valid <= 1'b0;
      if (state == DEV_CLEAR || state == DEV_HOLD)
        config_addr <= '0;
      else if (state == DEV_LOAD && byte_evt)
      begin
        cfg_byte       <= link_byte;
        cfg_byte_valid <= 1'b1;
        config_addr    <= config_addr + 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      load_en           <= 1'b0;
      link.init_out_dev <= 1'b0;
      link.init_oe_dev  <= 1'b1;
      link.done_out_dev <= 1'b0;
      link.done_oe_dev  <= 1'b1;
      global_set_reset  <= 1'b1;
      configured        <= 1'b0;
      config_error      <= 1'b0;
    end
    else
    begin
      load_en          <= state == DEV_LOAD || state == DEV_STARTUP;
      link.init_oe_dev <= state == DEV_HOLD || state == DEV_CLEAR ||
                          state == DEV_ERROR;
      link.done_oe_dev <= state != DEV_DONE;
      global_set_reset <= state != DEV_DONE;
      configured       <= state == DEV_DONE && filt[SB_DONE];
      config_error     <= state == DEV_ERROR;
    end
  end

  // Link domain: the clear from the loading enable acts at once. The link
  // clock stands still between the program pulse and the first data bit,
  // so an enable synchronised on that clock would swallow the first bits.
  // The enable rises some clocks before the host's first rising edge.
  always_ff @(posedge link.config_clock_pin or negedge load_en)
  begin
    if (!load_en)
    begin
      sr        <= '0;
      bit_cnt   <= 3'h0;
      byte_cnt  <= '0;
      own_done  <= 1'b0;
      link_tog  <= 1'b0;
      link_byte <= '0;
    end
    else
    begin
      sr      <= {sr[BYTE_W-2:0], link.din};
      bit_cnt <= bit_cnt + 1'b1;
      if (bit_cnt == 3'h7 && !own_done)
      begin
        link_byte <= {sr[BYTE_W-2:0], link.din};
        link_tog  <= !link_tog;
        byte_cnt  <= byte_cnt + 1'b1;
        if (byte_cnt == ADDR_W'(CONFIG_BYTES - 1))
          own_done <= 1'b1;
      end
    end
  end

  // Start-up runs on the extra clocks after the device's own bytes.
  always_ff @(posedge link.config_clock_pin or negedge load_en)
  begin
    if (!load_en)
    begin
      su_cnt  <= '0;
      su_done <= 1'b0;
    end
    else if (own_done && !su_done)
    begin
      su_cnt <= su_cnt + 1'b1;
      if (su_cnt == SU_W'(STARTUP_CLKS - 1))
        su_done <= 1'b1;
    end
  end

  // Chain length: a stream past the limit is flagged as an error.
  always_ff @(posedge link.config_clock_pin or negedge load_en)
  begin
    if (!load_en)
    begin
      total_bits <= '0;
      overflow   <= 1'b0;
    end
    else if (total_bits != MAX_CHAIN_BITS)
      total_bits <= total_bits + 1'b1;
    else
      overflow <= 1'b1;
  end

  // Bits after the device's own data go on down the chain while loading is enabled.
  always_ff @(negedge link.config_clock_pin or negedge load_en)
  begin
    if (!load_en)
      link.dout <= 1'b1;
    else
      link.dout <= own_done ? sr[0] : 1'b1;
  end
endmodule

// ---- tb/scfg_asserts.sv ----
// Checker for the configuration pins between the host and the device.
// Assumes the bench instantiates it beside the interface that joins both ends.
`timescale 1ns/1ps
module scfg_asserts
  import scfg_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       config_clock_pin,
  input wire logic       din,
  input wire logic       program_request_n,
  input wire logic [2:0] mode,
  input wire logic       init_in,
  input wire logic       done_in
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  // Counts how long the program request has been held low.
  logic [5:0] low_cnt;

  always_ff @(posedge clock)
  begin
    if (rst || program_request_n)
      low_cnt <= 6'h00;
    else if (low_cnt != 6'h3F)
      low_cnt <= low_cnt + 6'h01;
  end

  a_prog_width: assert property (
    $rose(program_request_n) |-> low_cnt >= PROG_MIN_CYC)
    else $error("program request pulse too short");
  a_mode_slave: assert property (
    mode == MODE_SLAVE_SERIAL)
    else $error("mode pins not at slave serial");
  a_prog_clears: assert property (
    $fell(program_request_n) |-> ##[1:6] (!init_in && !done_in))
    else $error("program request did not pull init and done low");
  a_init_clear: assert property (
    $rose(program_request_n) |=> !init_in [*8])
    else $error("init released too early after program request");
  a_done_stays: assert property (
    done_in && program_request_n |=> done_in)
    else $error("done fell without program request");
  a_done_order: assert property (
    $rose(done_in) |-> init_in && $past(init_in, 256))
    else $error("done rose without a finished load");
  a_config_clock_pin_shape: assert property (
    $rose(config_clock_pin) |=> config_clock_pin ##1 !config_clock_pin)
    else $error("config clock high phase is not two cycles");
  a_din_setup: assert property (
    $rose(config_clock_pin) |-> $stable(din))
    else $error("serial data changed at config clock rise");
  a_clk_after_init: assert property (
    $rose(config_clock_pin) && program_request_n |-> init_in)
    else $error("config clock ran before init went high");

  cover property ($rose(done_in));
  cover property ($rose(init_in));
  cover property ($fell(program_request_n) ##1 done_in);
endmodule

// ---- tb/test_serial_config_sequencer.sv ----
// Testbench joining the host and the device across one interface.
// Assumes a second device, driven by hand, for a bad mode selection.
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module test_serial_config_sequencer;
  import scfg_pkg::*;

  typedef struct packed
  {
    logic [9:0] hold;
    logic [7:0] base;
    logic       ok;
  } scfg_row_t;

  localparam scfg_row_t ROWS [3] = '{'{10'h000, 8'hA5, 1'b1},
    '{10'h000, 8'h00, 1'b1}, '{10'h12C, 8'hFF, 1'b1}};

  logic                clock      = 1'b0;
  logic                rst        = 1'b1;
  logic                start      = 1'b0;
  logic                stream_end = 1'b0;
  logic                hold_init  = 1'b0;
  logic [7:0]          in_data    = 8'h00;
  logic                in_valid   = 1'b0;
  logic                in_ready;
  logic                busy;
  logic                success;
  logic                failure;
  logic [BYTE_W-1:0]   cfg_byte;
  logic                cfg_byte_valid;
  logic [ADDR_W-1:0]   config_addr;
  logic [2:0]          mode_latched;
  logic                global_set_reset;
  logic                configured;
  logic                config_error;
  logic                global_set_reset_b;
  logic                configured_b;
  logic                config_error_b;
  logic [7:0]          got_q [$];
  int                  num_errors = 0;
  int                  checked    = 0;

  always #12.5 clock = ~clock;

  scfg_if link_a ();
  scfg_if link_b ();

  scfg_host u_scfg_host (.link(link_a.host), .clock(clock), .rst(rst),
    .start(start), .stream_end(stream_end), .hold_init(hold_init),
    .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
    .busy(busy), .success(success), .failure(failure));

  scfg_device u_scfg_device (.link(link_a.dev), .clock(clock), .rst(rst),
    .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
    .config_addr(config_addr), .mode_latched(mode_latched),
    .global_set_reset(global_set_reset), .configured(configured),
    .config_error(config_error));

  scfg_device u_scfg_device_b (.link(link_b.dev), .clock(clock), .rst(rst),
    .cfg_byte(), .cfg_byte_valid(), .config_addr(), .mode_latched(),
    .global_set_reset(global_set_reset_b), .configured(configured_b),
    .config_error(config_error_b));

  scfg_asserts u_scfg_asserts (.clock(clock), .rst(rst),
    .config_clock_pin(link_a.config_clock_pin), .din(link_a.din),
    .program_request_n(link_a.program_request_n), .mode(link_a.mode),
    .init_in(link_a.init_in), .done_in(link_a.done_in));

  // The hand-driven host of the second device selects a wrong mode.
  initial
  begin
    link_b.config_clock_pin  = 1'b0;
    link_b.din               = 1'b1;
    link_b.program_request_n = 1'b1;
    link_b.mode              = 3'h3;
    link_b.init_out_host     = 1'b0;
    link_b.init_oe_host      = 1'b0;
  end

  always @(negedge clock)
  begin
    if (cfg_byte_valid === 1'b1)
      got_q.push_back(cfg_byte);
  end

  task stop_test;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task push_byte(input logic [7:0] b);
    int n;
    begin
      n = 0;
      @(posedge clock);
      in_data  <= b;
      in_valid <= 1'b1;
      @(negedge clock);
      while (in_ready !== 1'b1 && n < 3000)
      begin
        n++;
        @(negedge clock);
      end
      @(posedge clock);
      in_valid <= 1'b0;
    end
  endtask

  task run(input scfg_row_t r);
    int n;
    begin
      n = 0;
      got_q.delete();
      for (int i = 0; i < FIFO_DEPTH; i++)
        push_byte(r.base ^ i[7:0]);
      repeat (2) @(negedge clock);
      `CHECK(in_ready, 1'b0)
      @(posedge clock);
      hold_init <= (r.hold != 10'h000);
      start     <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      repeat (40) @(negedge clock);
      `CHECK(link_a.done_in, 1'b0)
      `CHECK(link_a.init_in, 1'b0)
      `CHECK(global_set_reset, 1'b1)
      if (r.hold != 10'h000)
      begin
        repeat (r.hold) @(negedge clock);
        `CHECK(link_a.init_in, 1'b0)
        `CHECK(busy, 1'b1)
        `CHECK(got_q.size(), 0)
        @(posedge clock);
        hold_init <= 1'b0;
      end
      for (int i = FIFO_DEPTH; i < CONFIG_BYTES; i++)
        push_byte(r.base ^ i[7:0]);
      `CHECK(global_set_reset, 1'b1)
      @(posedge clock);
      stream_end <= 1'b1;
      while (success !== 1'b1 && failure !== 1'b1 && n < 5000)
      begin
        n++;
        @(negedge clock);
      end
      repeat (4) @(negedge clock);
      `CHECK(success, r.ok)
      `CHECK(failure, ~r.ok)
      `CHECK(configured, r.ok)
      `CHECK(global_set_reset, ~r.ok)
      `CHECK(config_addr, ADDR_W'(CONFIG_BYTES))
      `CHECK(mode_latched, MODE_SLAVE_SERIAL)
      `CHECK(link_a.dout, 1'b1)
      `CHECK(got_q.size(), CONFIG_BYTES)
      for (int i = 0; i < CONFIG_BYTES; i++)
        `CHECK(got_q[i], r.base ^ i[7:0])
      @(posedge clock);
      stream_end <= 1'b0;
    end
  endtask

  task bad_mode;
    begin
      @(posedge clock);
      link_b.program_request_n <= 1'b0;
      for (int i = 0; i < 2 * PROG_MIN_CYC; i++)
      begin
        @(posedge clock);
        if (i % 2 == 1)
          link_b.config_clock_pin <= ~link_b.config_clock_pin;
      end
      @(posedge clock);
      link_b.program_request_n <= 1'b1;
      link_b.config_clock_pin  <= 1'b0;
      repeat (20) @(negedge clock);
      `CHECK(link_b.init_in, 1'b0)
      repeat (CLEAR_CYC + 40) @(negedge clock);
      `CHECK(config_error_b, 1'b1)
      `CHECK(link_b.init_in, 1'b0)
      `CHECK(configured_b, 1'b0)
      `CHECK(global_set_reset_b, 1'b1)
    end
  endtask

  initial
  begin
    #(25 * 20000);
    num_errors++;
    stop_test();
  end

  initial
  begin
    repeat (9) @(negedge clock);
    `CHECK(busy, 1'b0)
    `CHECK(in_ready, 1'b0)
    `CHECK(link_a.program_request_n, 1'b1)
    `CHECK(link_a.done_in, 1'b0)
    `CHECK(global_set_reset, 1'b1)
    @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++)
      run(ROWS[k]);
    bad_mode();
    stop_test();
  end
endmodule
